// *** verilog/global_config_control_regs.sv ***
// global configuration and control register bank of the overhead terminator
// assumes register port strobes and all event inputs are on clk
`timescale 1ns/1ps

// Functional notes
// - interrupt pin drives only when enabled and an unmasked interrupt is active
// - alarm freeze holds a status register while its alarm interrupt is active
// - byte-change freeze holds a received byte register while its interrupt is active
// - counter test makes counters overflow at 7, 31 or 3
// - receive retime off bit resets to one; zero retimes receive side
// - with receive retiming, overhead bytes are regenerated, not passed through
// - transmit side retiming is always on
// - trace monitor select zero ignores J0; one monitors it
// - data bus enable resets to zero and gates all data buses
// - read-only 8-bit version code register; writes ignored
// - write to snapshot address buffers and clears every counter
// - counter address reads return held snapshot, live counting undisturbed
// - write to a counter's top byte buffers only that counter
// - operating mode field bits 4:2 at 50H, reset terminal
module global_config_control_regs #(
	parameter int NUM_COUNTERS = 7,
	parameter int COUNTER_WIDTH = 16,
	parameter int NUM_STATUS = 6,
	parameter int NUM_BYTES = 4,
	parameter logic [7:0] VERSION_CODE = global_cfg_pkg::VERSION_CODE_DEFAULT,
	// top byte address of each counter, one byte per counter
	parameter logic [NUM_COUNTERS*8-1:0] COUNTER_MSB_ADDRS = 56'h10_12_14_16_18_1A_1C,
	// class of each counter: short, bit or block limit
	parameter logic [NUM_COUNTERS*2-1:0] COUNTER_CLASS = 14'h0699
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// microprocessor register port
	input wire global_cfg_pkg::reg_req_t req,
	output logic [7:0] rdata,
	output logic rvalid,
	// interrupt sources from the section logic
	input wire logic irq_any_unmasked,
	input wire logic [NUM_STATUS-1:0] status_alarm_irq,
	input wire logic [NUM_STATUS*8-1:0] status_live,
	input wire logic [NUM_BYTES-1:0] byte_change_irq,
	input wire logic [NUM_BYTES*8-1:0] rx_byte_live,
	// counting events
	input wire logic [NUM_COUNTERS-1:0] count_event,
	// outputs to the chip
	output logic irq_out,
	output logic [NUM_STATUS*8-1:0] status_view,
	output logic [NUM_BYTES*8-1:0] rx_byte_view,
	output logic [NUM_COUNTERS-1:0] counter_overflow,
	output logic [NUM_COUNTERS*COUNTER_WIDTH-1:0] counter_held,
	output global_cfg_pkg::global_ctrl_t ctrl,
	output logic [2:0] operating_mode_field,
	output logic rx_retime_on,
	output logic oh_passthrough_en,
	output logic tx_retime_on,
	output logic trace_mismatch_alarm_en,
	output logic data_buses_on
);

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	// one address compare, shared by every strobe decode
	function automatic logic hits(input logic [7:0] a, input logic [7:0] b, input logic s);
		hits = s && (a == b);
	endfunction : hits

	function automatic int limit_of(input logic [1:0] cls);
		unique case (global_cfg_pkg::counter_class_t'(cls))
			global_cfg_pkg::CNT_SHORT: limit_of = global_cfg_pkg::TEST_LIMIT_SHORT;
			global_cfg_pkg::CNT_BIT: limit_of = global_cfg_pkg::TEST_LIMIT_BIT;
			global_cfg_pkg::CNT_BLOCK: limit_of = global_cfg_pkg::TEST_LIMIT_BLOCK;
			default: limit_of = global_cfg_pkg::TEST_LIMIT_SHORT;
		endcase
	endfunction : limit_of

	// ----------------------------------------------------------------
	// control registers
	// ----------------------------------------------------------------
	logic [7:0] ctl_reg, ctl_next;
	logic [2:0] mode_reg, mode_next;

	always_comb begin
		ctl_next = ctl_reg;
		mode_next = mode_reg;
		if (hits(req.addr, global_cfg_pkg::GLOBAL_CONTROL_TWO_ADDR, req.wr)) begin
			ctl_next = req.wdata & global_cfg_pkg::GLOBAL_CONTROL_TWO_WMASK;
		end
		if (hits(req.addr, global_cfg_pkg::OPER_CONFIG_ONE_ADDR, req.wr)) begin
			mode_next = req.wdata[global_cfg_pkg::OPERATING_MODE_MSB:
				global_cfg_pkg::OPERATING_MODE_LSB];
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			ctl_reg <= global_cfg_pkg::GLOBAL_CONTROL_TWO_RESET;
			mode_reg <= global_cfg_pkg::OPERATING_MODE_RESET;
		end else begin
			ctl_reg <= ctl_next;
			mode_reg <= mode_next;
		end
	end

	global_cfg_pkg::global_ctrl_t c;
	assign c.irq_pin_enable = ctl_reg[global_cfg_pkg::IRQ_PIN_ENABLE_BIT];
	assign c.alarm_status_freeze = ctl_reg[global_cfg_pkg::ALARM_STATUS_FREEZE_BIT];
	assign c.rx_byte_change_freeze = ctl_reg[global_cfg_pkg::RX_BYTE_CHANGE_FREEZE_BIT];
	assign c.counter_overflow_test = ctl_reg[global_cfg_pkg::COUNTER_OVERFLOW_TEST_BIT];
	assign c.rx_retime_off = ctl_reg[global_cfg_pkg::RX_RETIME_OFF_BIT];
	assign c.section_trace_monitor_sel = ctl_reg[global_cfg_pkg::SECTION_TRACE_MONITOR_SEL_BIT];
	assign c.data_buses_enable = ctl_reg[global_cfg_pkg::DATA_BUSES_ENABLE_BIT];

	// ----------------------------------------------------------------
	// derived control outputs, registered
	// ----------------------------------------------------------------
	logic irq_reg, irq_next;
	logic rxrt_reg, rxrt_next;
	logic pass_reg, pass_next;
	logic tim_reg, tim_next;
	logic bus_reg, bus_next;
	logic txrt_reg, txrt_next;
	global_cfg_pkg::global_ctrl_t ctrl_reg, ctrl_next;
	logic [2:0] mode_out_reg, mode_out_next;

	always_comb begin
		irq_next = c.irq_pin_enable && irq_any_unmasked;
		rxrt_next = !c.rx_retime_off;
		pass_next = c.rx_retime_off;
		tim_next = c.section_trace_monitor_sel;
		bus_next = c.data_buses_enable;
		txrt_next = 1'b1;
		// copies lag the register by one clock, like every derived output
		ctrl_next = c;
		mode_out_next = mode_reg;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			irq_reg <= 1'b0;
			rxrt_reg <= 1'b0;
			pass_reg <= 1'b1;
			tim_reg <= 1'b0;
			bus_reg <= 1'b0;
			txrt_reg <= 1'b1;
			ctrl_reg <= '0;
			mode_out_reg <= global_cfg_pkg::OPERATING_MODE_RESET;
		end else begin
			irq_reg <= irq_next;
			rxrt_reg <= rxrt_next;
			pass_reg <= pass_next;
			tim_reg <= tim_next;
			bus_reg <= bus_next;
			txrt_reg <= txrt_next;
			ctrl_reg <= ctrl_next;
			mode_out_reg <= mode_out_next;
		end
	end

	assign irq_out = irq_reg;
	assign rx_retime_on = rxrt_reg;
	assign oh_passthrough_en = pass_reg;
	// a flop, not a tie, so this pin times like the others
	assign tx_retime_on = txrt_reg;
	assign trace_mismatch_alarm_en = tim_reg;
	assign data_buses_on = bus_reg;
	assign ctrl = ctrl_reg;
	assign operating_mode_field = mode_out_reg;

	// ----------------------------------------------------------------
	// frozen status and received byte views
	// ----------------------------------------------------------------
	logic [NUM_STATUS*8-1:0] stat_reg, stat_next;
	logic [NUM_BYTES*8-1:0] byte_reg, byte_next;

	// a frozen byte catches up with live data once its interrupt drops
	always_comb begin
		stat_next = stat_reg;
		byte_next = byte_reg;
		for (int i = 0; i < NUM_STATUS; i++) begin
			if (!(c.alarm_status_freeze && status_alarm_irq[i])) begin
				stat_next[i*8 +: 8] = status_live[i*8 +: 8];
			end
		end
		for (int j = 0; j < NUM_BYTES; j++) begin
			if (!(c.rx_byte_change_freeze && byte_change_irq[j])) begin
				byte_next[j*8 +: 8] = rx_byte_live[j*8 +: 8];
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			stat_reg <= '0;
			byte_reg <= '0;
		end else begin
			stat_reg <= stat_next;
			byte_reg <= byte_next;
		end
	end

	assign status_view = stat_reg;
	assign rx_byte_view = byte_reg;

	// ----------------------------------------------------------------
	// performance counters
	// ----------------------------------------------------------------
	logic snap_all;
	logic [NUM_COUNTERS-1:0] snap_one;
	logic [NUM_COUNTERS*COUNTER_WIDTH-1:0] held_w;
	logic [NUM_COUNTERS-1:0] ovf_w;

	// snapshot and clear share one edge, so no event slips between them
	// data value ignored
	assign snap_all = hits(req.addr, global_cfg_pkg::SNAPSHOT_ALL_COUNTERS_ADDR, req.wr);

	genvar k;
	generate
		for (k = 0; k < NUM_COUNTERS; k++) begin : g_cnt
			// class per counter picks its reduced wrap point under test
			// single counter snapshot
			assign snap_one[k] = hits(req.addr, COUNTER_MSB_ADDRS[k*8 +: 8], req.wr);
			perf_counter #(
				.WIDTH(COUNTER_WIDTH),
				.TEST_LIMIT(limit_of(COUNTER_CLASS[k*2 +: 2]))
			) u_cnt (
				.clk(clk),
				.rst(rst),
				.count_event(count_event[k]),
				.snapshot(snap_all || snap_one[k]),
				.test_mode(c.counter_overflow_test),
				.held(held_w[k*COUNTER_WIDTH +: COUNTER_WIDTH]),
				.overflow(ovf_w[k])
			);
		end
	endgenerate

	assign counter_held = held_w;
	assign counter_overflow = ovf_w;

	// ----------------------------------------------------------------
	// read path
	// ----------------------------------------------------------------
	logic [7:0] rdata_reg, rdata_next;
	logic rvalid_reg, rvalid_next;

	always_comb begin
		rdata_next = 8'h00;
		if (req.addr == global_cfg_pkg::GLOBAL_CONTROL_TWO_ADDR) begin
			rdata_next = ctl_reg;
		end else if (req.addr == global_cfg_pkg::OPER_CONFIG_ONE_ADDR) begin
			rdata_next[global_cfg_pkg::OPERATING_MODE_MSB:
				global_cfg_pkg::OPERATING_MODE_LSB] = mode_reg;
		end else if (req.addr == global_cfg_pkg::CHIP_VERSION_CODE_ADDR) begin
			rdata_next = VERSION_CODE;
		end
		for (int n = 0; n < NUM_COUNTERS; n++) begin
			if (req.addr == COUNTER_MSB_ADDRS[n*8 +: 8]) begin
				rdata_next = held_w[n*COUNTER_WIDTH + COUNTER_WIDTH-8 +: 8];
			end else if (req.addr == COUNTER_MSB_ADDRS[n*8 +: 8] + 8'h01) begin
				rdata_next = held_w[n*COUNTER_WIDTH +: 8];
			end
		end
		rvalid_next = req.rd;
		// no strobe: the last answer stays up until the next read
		if (!req.rd) begin
			rdata_next = rdata_reg;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			rdata_reg <= 8'h00;
			rvalid_reg <= 1'b0;
		end else begin
			rdata_reg <= rdata_next;
			rvalid_reg <= rvalid_next;
		end
	end

	assign rdata = rdata_reg;
	assign rvalid = rvalid_reg;

endmodule : global_config_control_regs

// *** verilog/global_cfg_pkg.sv ***
// global configuration registers: offsets, field positions, reset values, types
// assumes an 8-bit microprocessor register port with 8-bit addresses
package global_cfg_pkg;

	// ----------------------------------------------------------------
	// register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] OPER_CONFIG_ONE_ADDR = 8'h50;
	localparam logic [7:0] GLOBAL_CONTROL_TWO_ADDR = 8'h51;
	localparam logic [7:0] CHIP_VERSION_CODE_ADDR = 8'h52;
	localparam logic [7:0] SNAPSHOT_ALL_COUNTERS_ADDR = 8'h54;

	// ----------------------------------------------------------------
	// control register field positions
	// ----------------------------------------------------------------
	localparam int IRQ_PIN_ENABLE_BIT = 7;
	localparam int ALARM_STATUS_FREEZE_BIT = 6;
	localparam int RX_BYTE_CHANGE_FREEZE_BIT = 5;
	localparam int COUNTER_OVERFLOW_TEST_BIT = 4;
	localparam int RX_RETIME_OFF_BIT = 3;
	localparam int SECTION_TRACE_MONITOR_SEL_BIT = 2;
	localparam int DATA_BUSES_ENABLE_BIT = 0;
	localparam int OPERATING_MODE_LSB = 2;
	localparam int OPERATING_MODE_MSB = 4;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] GLOBAL_CONTROL_TWO_RESET = 8'h08;
	localparam logic [7:0] GLOBAL_CONTROL_TWO_WMASK = 8'hFD;
	localparam logic [2:0] OPERATING_MODE_RESET = 3'h4;
	// arbitrary version value, not tied to any part
	localparam logic [7:0] VERSION_CODE_DEFAULT = 8'hA5;

	// ----------------------------------------------------------------
	// reduced overflow limits under counter test
	// ----------------------------------------------------------------
	localparam int TEST_LIMIT_SHORT = 7;
	localparam int TEST_LIMIT_BIT = 31;
	localparam int TEST_LIMIT_BLOCK = 3;

	typedef enum logic [1:0] {
		CNT_SHORT,
		CNT_BIT,
		CNT_BLOCK
	} counter_class_t;

	// decoded control bits handed to the datapath
	typedef struct packed {
		logic irq_pin_enable;
		logic alarm_status_freeze;
		logic rx_byte_change_freeze;
		logic counter_overflow_test;
		logic rx_retime_off;
		logic section_trace_monitor_sel;
		logic data_buses_enable;
	} global_ctrl_t;

	// register port request
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} reg_req_t;

endpackage : global_cfg_pkg

// *** verilog/perf_counter.sv ***
// one performance counter with snapshot buffer and overflow flag
// assumes events and snapshot strobes are on the system clock
`timescale 1ns/1ps

module perf_counter #(
	parameter int WIDTH = 16,
	parameter int TEST_LIMIT = 7
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// control
	input wire logic count_event,
	input wire logic snapshot,
	input wire logic test_mode,
	// results
	output logic [WIDTH-1:0] held,
	output logic overflow
);

	logic [WIDTH-1:0] count_reg, count_next;
	logic [WIDTH-1:0] held_reg, held_next;
	logic ovf_reg, ovf_next;
	logic at_limit;

	always_comb begin
		at_limit = test_mode ? (count_reg >= WIDTH'(TEST_LIMIT)) : (&count_reg);
		count_next = count_reg;
		held_next = held_reg;
		ovf_next = 1'b0;
		if (snapshot) begin
			held_next = count_reg;
			count_next = count_event ? WIDTH'(1) : '0;
		end else if (count_event) begin
			if (at_limit) begin
				count_next = '0;
				ovf_next = 1'b1;
			end else begin
				count_next = count_reg + WIDTH'(1);
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			count_reg <= '0;
			held_reg <= '0;
			ovf_reg <= 1'b0;
		end else begin
			count_reg <= count_next;
			held_reg <= held_next;
			ovf_reg <= ovf_next;
		end
	end

	assign held = held_reg;
	assign overflow = ovf_reg;

endmodule : perf_counter

// *** tb/global_cfg_sva.sv ***
// port checker for the global control register bank
// assumes one clock and a synchronous active-high reset
`timescale 1ns/1ps

module global_cfg_sva #(
	parameter int NUM_STATUS = 6,
	parameter int NUM_BYTES = 4,
	parameter logic [7:0] VERSION_CODE = global_cfg_pkg::VERSION_CODE_DEFAULT
) (
	// clock, reset and register port
	input wire logic clk,
	input wire logic rst,
	input wire global_cfg_pkg::reg_req_t req,
	input wire logic [7:0] rdata,
	input wire logic rvalid,
	// watched sources and outputs
	input wire logic irq_any_unmasked,
	input wire logic irq_out,
	input wire logic [NUM_STATUS-1:0] status_alarm_irq,
	input wire logic [NUM_STATUS*8-1:0] status_view,
	input wire logic [NUM_BYTES-1:0] byte_change_irq,
	input wire logic [NUM_BYTES*8-1:0] rx_byte_view,
	input wire global_cfg_pkg::global_ctrl_t ctrl,
	input wire logic rx_retime_on,
	input wire logic oh_passthrough_en,
	input wire logic tx_retime_on
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	a_irq_cause: assert property (
		irq_out |-> $past(irq_any_unmasked)) else $error("irq pin without a source");
	a_irq_masked: assert property (
		!ctrl.irq_pin_enable ##1 !ctrl.irq_pin_enable |-> !irq_out)
		else $error("irq pin active while disabled");
	a_alarm_freeze: assert property (
		ctrl.alarm_status_freeze && status_alarm_irq[0] ##1 ctrl.alarm_status_freeze
		|-> $stable(status_view[7:0])) else $error("status changed while frozen");
	a_byte_freeze: assert property (
		ctrl.rx_byte_change_freeze && byte_change_irq[0] ##1 ctrl.rx_byte_change_freeze
		|-> $stable(rx_byte_view[7:0])) else $error("rx byte changed while frozen");
	a_retime_pair: assert property (
		rx_retime_on != oh_passthrough_en) else $error("retime and passthrough disagree");
	a_tx_retime: assert property (
		tx_retime_on) else $error("transmit retiming off");
	a_version_read: assert property (
		req.rd && req.addr == global_cfg_pkg::CHIP_VERSION_CODE_ADDR
		|=> rvalid && rdata == VERSION_CODE) else $error("version code read wrong");
	a_reserved_zero: assert property (
		req.rd && req.addr == global_cfg_pkg::GLOBAL_CONTROL_TWO_ADDR
		|=> rdata[1] == 1'b0) else $error("reserved bit reads one");
	a_read_valid: assert property (
		rvalid == $past(req.rd)) else $error("read answer late or spurious");

	c_irq: cover property (irq_out);
	c_freeze: cover property (ctrl.alarm_status_freeze && status_alarm_irq[0]);
	c_version: cover property (rvalid && rdata == VERSION_CODE);
endmodule : global_cfg_sva

bind global_config_control_regs global_cfg_sva #(
	.NUM_STATUS(NUM_STATUS),
	.NUM_BYTES(NUM_BYTES),
	.VERSION_CODE(VERSION_CODE)
) global_cfg_sva_i (.clk, .rst, .req, .rdata, .rvalid, .irq_any_unmasked, .irq_out,
	.status_alarm_irq, .status_view, .byte_change_irq, .rx_byte_view, .ctrl,
	.rx_retime_on, .oh_passthrough_en, .tx_retime_on);

// *** tb/tb_global_config_control_regs.sv ***
// self-checking bench for the global control register bank
// assumes default parameters; inputs change on the falling edge
`timescale 1ns/1ps

module tb_global_config_control_regs;
	logic clk = 1'b0;
	logic rst = 1'b1;
	global_cfg_pkg::reg_req_t req = '0;
	logic irq_any_unmasked = 1'b0;
	logic [5:0] status_alarm_irq = '0;
	logic [47:0] status_live = '0;
	logic [3:0] byte_change_irq = '0;
	logic [31:0] rx_byte_live = '0;
	logic [6:0] count_event = '0;
	logic [7:0] rdata;
	logic rvalid, irq_out, rx_retime_on, oh_passthrough_en, tx_retime_on;
	logic trace_mismatch_alarm_en, data_buses_on;
	logic [47:0] status_view;
	logic [31:0] rx_byte_view;
	logic [6:0] counter_overflow;
	logic [111:0] counter_held;
	logic [2:0] operating_mode_field;
	global_cfg_pkg::global_ctrl_t ctrl;
	int miscompares = 0;
	int cmp_count = 0;
	int cycles = 0;

	global_config_control_regs global_config_control_regs_i (.clk, .rst, .req, .rdata,
		.rvalid, .irq_any_unmasked, .status_alarm_irq, .status_live, .byte_change_irq,
		.rx_byte_live, .count_event, .irq_out, .status_view, .rx_byte_view,
		.counter_overflow, .counter_held, .ctrl, .operating_mode_field, .rx_retime_on,
		.oh_passthrough_en, .tx_retime_on, .trace_mismatch_alarm_en, .data_buses_on);

	always #5 clk = ~clk;

	// run is under two hundred cycles; the ceiling only cuts a hang
	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			miscompares++;
			summarize();
		end
	end

	task automatic check(input string name, input logic [15:0] e, input logic [15:0] s);
		cmp_count++;
		if (s !== e) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", name, e, s);
		end
	endtask : check

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		req = '{1'b1, 1'b0, a, d};
		@(negedge clk);
		req.wr = 1'b0;
		@(negedge clk);
		@(negedge clk);
	endtask : wr

	task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
		@(negedge clk);
		req = '{1'b0, 1'b1, a, 8'h00};
		@(negedge clk);
		req.rd = 1'b0;
		check("rvalid", 16'h1, rvalid);
		check("rdata", e, rdata);
	endtask : rd_chk

	// overflow is a one-cycle pulse, so sample it right after the counting edge
	task automatic pulse(input int i, input int n, output logic ov);
		repeat (n) begin
			@(negedge clk);
			count_event[i] = 1'b1;
			@(negedge clk);
			count_event[i] = 1'b0;
			ov = counter_overflow[i];
		end
	endtask : pulse

	task automatic t_ctrl();
		rd_chk(8'h51, 8'h08);
		check("mode", 16'h4, operating_mode_field);
		check("buses", 16'h0, data_buses_on);
		check("passthru_rst", 16'h1, oh_passthrough_en);
		wr(8'h51, 8'hFF);
		rd_chk(8'h51, 8'hFD);
		check("ctrl", 16'h7F, ctrl);
		check("rx_retime", 16'h0, rx_retime_on);
		check("trace", 16'h1, trace_mismatch_alarm_en);
		check("buses_on", 16'h1, data_buses_on);
		check("passthru_on", 16'h1, oh_passthrough_en);
		wr(8'h51, 8'h00);
		check("passthru", 16'h0, oh_passthrough_en);
		check("rx_retime_on", 16'h1, rx_retime_on);
		check("tx_retime", 16'h1, tx_retime_on);
		check("trace_off", 16'h0, trace_mismatch_alarm_en);
		check("buses_off", 16'h0, data_buses_on);
		wr(8'h50, 8'h18);
		check("mode_new", 16'h6, operating_mode_field);
		rd_chk(8'h50, 8'h18);
		wr(8'h51, 8'h01);
		check("buses_back", 16'h1, data_buses_on);
		wr(8'h52, 8'h5A);
		rd_chk(8'h52, global_cfg_pkg::VERSION_CODE_DEFAULT);
		rd_chk(8'h3F, 8'h00);
	endtask : t_ctrl

	task automatic t_irq();
		irq_any_unmasked = 1'b1;
		repeat (3) @(negedge clk);
		check("irq_masked", 16'h0, irq_out);
		wr(8'h51, 8'h80);
		check("irq_on", 16'h1, irq_out);
		irq_any_unmasked = 1'b0;
		@(negedge clk);
		check("irq_gone", 16'h0, irq_out);
	endtask : t_irq

	task automatic t_freeze();
		status_live[7:0] = 8'h11;
		rx_byte_live[7:0] = 8'h22;
		wr(8'h51, 8'h60);
		status_alarm_irq[0] = 1'b1;
		byte_change_irq[0] = 1'b1;
		status_live[7:0] = 8'hAA;
		rx_byte_live[7:0] = 8'hBB;
		repeat (3) @(negedge clk);
		check("status_hold", 16'h11, status_view[7:0]);
		check("byte_hold", 16'h22, rx_byte_view[7:0]);
		wr(8'h51, 8'h00);
		@(negedge clk);
		check("status_upd", 16'hAA, status_view[7:0]);
		check("byte_upd", 16'hBB, rx_byte_view[7:0]);
	endtask : t_freeze

	task automatic t_snap();
		logic ov;
		wr(8'h54, 8'h00);
		pulse(0, 3, ov);
		pulse(1, 2, ov);
		@(negedge clk);
		req = '{1'b1, 1'b0, 8'h54, 8'h5A};
		count_event[0] = 1'b1;
		@(negedge clk);
		req.wr = 1'b0;
		count_event[0] = 1'b0;
		check("held0", 16'h3, counter_held[15:0]);
		check("held1", 16'h2, counter_held[31:16]);
		rd_chk(8'h1D, 8'h03);
		pulse(1, 1, ov);
		wr(8'h1C, 8'h00);
		check("fresh0", 16'h1, counter_held[15:0]);
		check("keep1", 16'h2, counter_held[31:16]);
	endtask : t_snap

	// one counter of each class: short 7, block 3, bit 31
	task automatic t_test();
		logic ov;
		int idx[3] = '{6, 1, 0};
		int lim[3] = '{7, 3, 31};
		wr(8'h51, 8'h10);
		wr(8'h54, 8'h00);
		for (int k = 0; k < 3; k++) begin
			pulse(idx[k], lim[k], ov);
			check("early_wrap", 16'h0, ov);
			pulse(idx[k], 1, ov);
			check("test_wrap", 16'h1, ov);
		end
		wr(8'h51, 8'h00);
		check("test_off", 16'h0, ctrl);
	endtask : t_test

	task automatic summarize();
		$display("comparisons %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : summarize

	initial begin
		repeat (16) @(negedge clk);
		rst = 1'b0;
		t_ctrl();
		t_irq();
		t_freeze();
		t_snap();
		t_test();
		summarize();
	end
endmodule : tb_global_config_control_regs
